// *** shared/frl_pkg.sv ***
package frl_pkg;

  // ----------------------------------------------------------------
  // Opcodes and prefix bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_FRAME_RELEASE = 8'hC9;
  localparam logic [7:0] OPC_FAR_LOAD_EXTRA = 8'hC4;
  localparam logic [7:0] PFX_BUS_LOCK = 8'hF0;
  localparam logic [7:0] PFX_ITER_NE = 8'hF2;
  localparam logic [7:0] PFX_ITER_EQ = 8'hF3;
  localparam logic [7:0] PFX_SEG_EXTRA = 8'h26;
  localparam logic [7:0] PFX_SEG_CS = 8'h2E;
  localparam logic [7:0] PFX_SEG_SS = 8'h36;
  localparam logic [7:0] PFX_SEG_DS = 8'h3E;

  // ----------------------------------------------------------------
  // Field positions and register numbers
  // ----------------------------------------------------------------
  localparam int MODRM_REG_LSB = 3;
  localparam logic [2:0] GPR_STACK_PTR = 3'h4;
  localparam logic [2:0] GPR_FRAME_PTR = 3'h5;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;

  // ----------------------------------------------------------------
  // Instruction lengths in clocks, counted from the opcode cycle
  // ----------------------------------------------------------------
  localparam logic [4:0] CLKS_FRAME_RELEASE = 5'h08;
  localparam logic [4:0] CLKS_FAR_LOAD_W16 = 5'h12;
  localparam logic [4:0] CLKS_FAR_LOAD_W8 = 5'h1A;
  localparam logic [4:0] CLKS_BUS_LOCK = 5'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEG_EXTRA = 2'b00,
    SEG_CS = 2'b01,
    SEG_SS = 2'b10,
    SEG_DS = 2'b11
  } frl_seg_t;

  typedef enum logic [2:0] {
    S_FETCH = 3'b000,
    S_MODRM = 3'b001,
    S_RELEASE = 3'b010,
    S_FARLOAD = 3'b011,
    S_FOREIGN = 3'b100
  } frl_state_t;

  typedef struct packed {
    logic lock;
    logic iter;
    logic iterEq;
    logic segValid;
    frl_seg_t seg;
  } frl_prefix_t;

  typedef struct packed {
    logic valid;
    frl_seg_t seg;
    logic [15:0] off;
  } frl_mem_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } frl_mem_rsp_t;

  typedef struct packed {
    logic valid;
    logic [2:0] idx;
    logic [15:0] data;
  } frl_gpr_wr_t;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } frl_flag_upd_t;

endpackage

// *** hw/frl_pin_sync.sv ***
`timescale 1ns/100ps

// Two-flop synchroniser, one per pin.
module frl_pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1[i] <= 1'b0;
          pinSync[i] <= 1'b0;
        end else begin
          stage1[i] <= pinIn[i];
          pinSync[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

// *** hw/frl_exec.sv ***
`timescale 1ns/100ps

// Function
// - Opcode C9 releases the stack frame in 8 clocks on both bus widths.
// - Frame release loads stack pointer from frame pointer, then pops frame pointer.
// - Opcode C4 with ModR/M loads far pointer; 18 clocks wide, 26 narrow bus.
// - Word at operand goes to selected register, word at operand+2 to extra seg.
// - Byte F0 locks the bus for the next instruction only, costing 1 clock.
// - Lock pin is asserted for the whole prefixed instruction, released at its end.
// - Lock may be combined with segment override and iterate prefixes.
// - Lock stays asserted across all iterations of an iterated string instruction.
// - On-chip DMA cycles are suppressed while a locked instruction runs.
// - External bus takeover requests are not acknowledged during a locked instruction.
// - Maskable interrupts are deferred while locked; the nonmaskable one is still taken.
// - Internal lock behaviour applies even where no lock pin exists.
// - Prefix bytes never modify the status flags.
module frl_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Instruction byte stream
  input wire logic fetchValid,
  input wire logic [7:0] fetchByte,
  output logic fetchReady,
  input wire logic [15:0] eaOffset,
  // Memory read port
  output frl_pkg::frl_mem_req_t memReq,
  input wire frl_pkg::frl_mem_rsp_t memRsp,
  // Register results
  output logic [15:0] stackPtr,
  output logic [15:0] framePtr,
  output logic [15:0] extraSeg,
  output frl_pkg::frl_gpr_wr_t gprWr,
  output logic [15:0] flags,
  input wire frl_pkg::frl_flag_upd_t flagUpd,
  // Other instructions, executed elsewhere
  output logic foreignStart,
  output logic [7:0] foreignOpcode,
  output frl_pkg::frl_prefix_t foreignPrefix,
  input wire logic foreignDone,
  output logic instrDone,
  // Pins and system arbitration
  input wire logic busNarrowPin,
  input wire logic holdReqPin,
  input wire logic intrPin,
  input wire logic nmiPin,
  output logic busLockN,
  output logic holdAck,
  output logic dmaInhibit,
  output logic intGrant,
  output logic nmiTake
);
  import frl_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation and strap capture
  // ----------------------------------------------------------------
  logic [3:0] pinSync;
  logic busNarrow, nmiLast;
  logic [1:0] strapAge;

  frl_pin_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn({nmiPin, intrPin, holdReqPin, busNarrowPin}),
    .pinSync(pinSync)
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  frl_state_t state, next_state;
  frl_prefix_t pfx, next_pfx;
  logic [4:0] cnt, next_cnt;
  logic [1:0] rdPhase, next_rdPhase;
  logic [2:0] regSel, next_regSel;
  logic [15:0] opOff, next_opOff;
  logic [15:0] next_stackPtr, next_framePtr, next_extraSeg, next_flags;
  frl_mem_req_t next_memReq;
  frl_gpr_wr_t next_gprWr;
  logic next_foreignStart, next_instrDone, next_holdAck;
  logic [7:0] next_foreignOpcode;
  logic [4:0] farLimit;
  logic take, boundary;

  assign take = fetchValid && fetchReady;
  assign fetchReady = (state == S_FETCH) || (state == S_MODRM);
  assign boundary = (state == S_FETCH) && !pfx.lock && !pfx.iter && !pfx.segValid;
  assign farLimit = busNarrow ? CLKS_FAR_LOAD_W8 : CLKS_FAR_LOAD_W16;
  assign busLockN = !pfx.lock;
  assign dmaInhibit = pfx.lock;
  assign intGrant = boundary && pinSync[2];
  assign foreignPrefix = pfx;

  always_comb begin
    next_state = state;
    next_pfx = pfx;
    next_cnt = (cnt == 5'h1F) ? cnt : cnt + 5'h01;
    next_rdPhase = rdPhase;
    next_regSel = regSel;
    next_opOff = opOff;
    next_stackPtr = stackPtr;
    next_framePtr = framePtr;
    next_extraSeg = extraSeg;
    next_flags = flagUpd.valid ? flagUpd.value : flags;
    next_memReq = memReq;
    next_gprWr = '0;
    next_foreignStart = 1'b0;
    next_foreignOpcode = foreignOpcode;
    next_instrDone = 1'b0;
    if (memRsp.valid) begin
      next_memReq.valid = 1'b0;
    end
    case (state)
      S_FETCH: begin
        next_cnt = 5'h01;
        if (take) begin
          case (fetchByte)
            PFX_BUS_LOCK: next_pfx.lock = 1'b1;
            PFX_ITER_NE, PFX_ITER_EQ: begin
              next_pfx.iter = 1'b1;
              next_pfx.iterEq = fetchByte[0];
            end
            PFX_SEG_EXTRA, PFX_SEG_CS, PFX_SEG_SS, PFX_SEG_DS: begin
              next_pfx.segValid = 1'b1;
              next_pfx.seg = frl_seg_t'(fetchByte[4:3]);
            end
            OPC_FRAME_RELEASE: begin
              next_state = S_RELEASE;
              next_stackPtr = framePtr;
              next_memReq = '{valid: 1'b1, seg: SEG_SS, off: framePtr};
              next_rdPhase = 2'h1;
            end
            OPC_FAR_LOAD_EXTRA: next_state = S_MODRM;
            default: begin
              next_state = S_FOREIGN;
              next_foreignStart = 1'b1;
              next_foreignOpcode = fetchByte;
            end
          endcase
        end
      end
      S_MODRM: begin
        if (take) begin
          next_state = S_FARLOAD;
          next_regSel = fetchByte[MODRM_REG_LSB +: 3];
          next_opOff = eaOffset;
          next_memReq.valid = 1'b1;
          next_memReq.seg = pfx.segValid ? pfx.seg : SEG_DS;
          next_memReq.off = eaOffset;
          next_rdPhase = 2'h1;
        end
      end
      S_RELEASE: begin
        if (memRsp.valid && rdPhase == 2'h1) begin
          next_framePtr = memRsp.data;
          next_stackPtr = stackPtr + WORD_STEP;
          next_rdPhase = 2'h3;
        end
        if (rdPhase == 2'h3 && cnt >= CLKS_FRAME_RELEASE - 5'h01) begin
          next_state = S_FETCH;
          next_pfx = '0;
          next_instrDone = 1'b1;
        end
      end
      S_FARLOAD: begin
        if (memRsp.valid && rdPhase == 2'h1) begin
          next_gprWr = '{valid: 1'b1, idx: regSel, data: memRsp.data};
          if (regSel == GPR_STACK_PTR) begin
            next_stackPtr = memRsp.data;
          end
          if (regSel == GPR_FRAME_PTR) begin
            next_framePtr = memRsp.data;
          end
          next_memReq.valid = 1'b1;
          next_memReq.off = opOff + WORD_STEP;
          next_rdPhase = 2'h2;
        end else if (memRsp.valid && rdPhase == 2'h2) begin
          next_extraSeg = memRsp.data;
          next_rdPhase = 2'h3;
        end
        if (rdPhase == 2'h3 && cnt >= farLimit - 5'h01) begin
          next_state = S_FETCH;
          next_pfx = '0;
          next_instrDone = 1'b1;
        end
      end
      S_FOREIGN: begin
        if (foreignDone) begin
          next_state = S_FETCH;
          next_pfx = '0;
          next_instrDone = 1'b1;
        end
      end
      default: next_state = S_FETCH;
    endcase
    next_holdAck = pinSync[1] && !next_pfx.lock && !next_memReq.valid;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_FETCH;
      pfx <= '0;
      cnt <= 5'h00;
      rdPhase <= 2'h0;
      regSel <= 3'h0;
      opOff <= RST_WORD;
      stackPtr <= RST_WORD;
      framePtr <= RST_WORD;
      extraSeg <= RST_WORD;
      flags <= RST_FLAGS;
      memReq <= '0;
      gprWr <= '0;
      foreignStart <= 1'b0;
      foreignOpcode <= 8'h00;
      instrDone <= 1'b0;
      holdAck <= 1'b0;
    end else begin
      state <= next_state;
      pfx <= next_pfx;
      cnt <= next_cnt;
      rdPhase <= next_rdPhase;
      regSel <= next_regSel;
      opOff <= next_opOff;
      stackPtr <= next_stackPtr;
      framePtr <= next_framePtr;
      extraSeg <= next_extraSeg;
      flags <= next_flags;
      memReq <= next_memReq;
      gprWr <= next_gprWr;
      foreignStart <= next_foreignStart;
      foreignOpcode <= next_foreignOpcode;
      instrDone <= next_instrDone;
      holdAck <= next_holdAck;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture and nonmaskable edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busNarrow <= 1'b0;
      strapAge <= 2'h0;
      nmiLast <= 1'b0;
      nmiTake <= 1'b0;
    end else begin
      // The strap is taken on the third edge, once the synchroniser holds the pin level.
      strapAge <= (strapAge == 2'h3) ? strapAge : strapAge + 2'h1;
      busNarrow <= (strapAge == 2'h2) ? pinSync[0] : busNarrow;
      nmiLast <= pinSync[3];
      nmiTake <= pinSync[3] && !nmiLast;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Cycles since the far-pointer opcode was taken, counted apart from the sequencer.
  logic [4:0] farAge;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      farAge <= 5'h00;
    end else if (state == S_FETCH && take && fetchByte == OPC_FAR_LOAD_EXTRA) begin
      farAge <= 5'h01;
    end else begin
      farAge <= (farAge == 5'h1F) ? farAge : farAge + 5'h01;
    end
  end

  sequence releaseAccept;
    state == S_FETCH && take && fetchByte == OPC_FRAME_RELEASE;
  endsequence
  sequence releaseQuiet;
    !instrDone [*7];
  endsequence

  a_release_min_len: assert property (@(posedge clk) disable iff (!rst_n)
    releaseAccept |=> releaseQuiet)
    else $error("frame release finished too early");
  a_release_sp_first: assert property (@(posedge clk) disable iff (!rst_n)
    releaseAccept |=> stackPtr == $past(framePtr) && memReq.off == $past(framePtr))
    else $error("stack pointer not loaded from frame pointer");
  a_pop_update: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_RELEASE && memRsp.valid && rdPhase == 2'h1
    |=> framePtr == $past(memRsp.data) && stackPtr == $past(stackPtr) + WORD_STEP)
    else $error("pop did not update frame and stack pointers");
  a_farload_len: assert property (@(posedge clk) disable iff (!rst_n)
    instrDone && $past(state) == S_FARLOAD
    |-> farAge >= (busNarrow ? CLKS_FAR_LOAD_W8 : CLKS_FAR_LOAD_W16))
    else $error("far-pointer load finished too early");
  a_farload_seg: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_FARLOAD && memRsp.valid && rdPhase == 2'h2
    |=> extraSeg == $past(memRsp.data) && memReq.off == opOff + WORD_STEP)
    else $error("extra segment not loaded from operand plus two");
  a_lock_drop: assert property (@(posedge clk) disable iff (!rst_n)
    instrDone |-> busLockN && !dmaInhibit)
    else $error("lock still asserted after instruction end");
  a_lock_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_FOREIGN && pfx.lock && !foreignDone |=> !busLockN)
    else $error("lock dropped during iterated instruction");
  a_hold_blocked: assert property (@(posedge clk) disable iff (!rst_n)
    !busLockN |-> !holdAck && dmaInhibit)
    else $error("bus granted while locked");
  a_int_deferred: assert property (@(posedge clk) disable iff (!rst_n)
    pfx.lock |-> !intGrant)
    else $error("maskable interrupt taken while locked");
  a_flags_kept: assert property (@(posedge clk) disable iff (!rst_n)
    state != S_FOREIGN && !flagUpd.valid |=> flags == $past(flags))
    else $error("flags changed by this block");
  a_lock_prefix: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_FETCH && take && fetchByte == PFX_BUS_LOCK |=> !busLockN && state == S_FETCH)
    else $error("lock prefix not taken in one clock");

endmodule

// *** verification/frl_mem_model.sv ***
`timescale 1ns/100ps

// Zero-wait or slow memory; the read bus drifts while no answer is driven.
module frl_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Read port
  input wire frl_pkg::frl_mem_req_t memReq,
  output frl_pkg::frl_mem_rsp_t memRsp,
  // Extra wait cycles before each answer
  input wire logic [3:0] waitCycles
);
  import frl_pkg::*;

  logic [3:0] cnt;
  logic gap;

  // The cycle after an answer is skipped so a following request is seen fresh.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memRsp <= '0;
      cnt <= 4'h0;
      gap <= 1'b0;
    end else begin
      memRsp.valid <= 1'b0;
      memRsp.data <= ~memRsp.data;
      gap <= 1'b0;
      cnt <= 4'h0;
      if (memReq.valid && !gap) begin
        if (cnt >= waitCycles) begin
          memRsp.valid <= 1'b1;
          memRsp.data <= memReq.off ^ {6'h00, memReq.seg, 8'h5A};
          gap <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

// *** verification/tb.sv ***
`timescale 1ns/100ps

module tb;
  import frl_pkg::*;

  typedef struct {int lat; logic [15:0] stack; logic [15:0] frame; logic [15:0] extra;} frl_note_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fetchValid = 1'b0;
  logic busNarrowPin = 1'b0;
  logic holdReqPin = 1'b0;
  logic intrPin = 1'b0;
  logic nmiPin = 1'b0;
  logic foreignDone = 1'b0;
  logic [7:0] fetchByte = 8'h00;
  logic [15:0] eaOffset = 16'h0000;
  logic [3:0] waitCycles = 4'h0;
  frl_flag_upd_t flagUpd = '0;
  frl_mem_req_t memReq;
  frl_mem_rsp_t memRsp;
  frl_gpr_wr_t gprWr;
  frl_prefix_t foreignPrefix;
  logic fetchReady, foreignStart, instrDone, busLockN, holdAck, dmaInhibit, intGrant, nmiTake;
  logic [15:0] stackPtr, framePtr, extraSeg, flags;
  logic [7:0] foreignOpcode;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 87;
  int start = 0;
  int nmiSeen = 0;
  int startSeen = 0;
  logic [15:0] expStack, expFrame, expExtra, fl;
  frl_note_t notes[$];
  logic [18:0] gprNotes[$];

  frl_exec DUT (.clk(clk), .rst_n(rst_n), .fetchValid(fetchValid), .fetchByte(fetchByte),
    .fetchReady(fetchReady), .eaOffset(eaOffset), .memReq(memReq), .memRsp(memRsp),
    .stackPtr(stackPtr), .framePtr(framePtr), .extraSeg(extraSeg), .gprWr(gprWr),
    .flags(flags), .flagUpd(flagUpd), .foreignStart(foreignStart),
    .foreignOpcode(foreignOpcode), .foreignPrefix(foreignPrefix), .foreignDone(foreignDone),
    .instrDone(instrDone), .busNarrowPin(busNarrowPin), .holdReqPin(holdReqPin),
    .intrPin(intrPin), .nmiPin(nmiPin), .busLockN(busLockN), .holdAck(holdAck),
    .dmaInhibit(dmaInhibit), .intGrant(intGrant), .nmiTake(nmiTake));

  frl_mem_model mem (.clk(clk), .rst_n(rst_n), .memReq(memReq), .memRsp(memRsp),
    .waitCycles(waitCycles));

  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // ----
  // Helpers
  // ----
  function automatic logic [15:0] memWord(frl_seg_t s, logic [15:0] o);
    return o ^ {6'h00, s, 8'h5A};
  endfunction

  task automatic check(logic [63:0] got, logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic put(logic [7:0] b);
    int n;
    n = 0;
    fetchValid = 1'b1;
    fetchByte = b;
    while (fetchReady !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    tick(1);
    // The opcode cycle ends at the taking edge, so the count starts one edge earlier.
    start = cyc - 1;
  endtask

  task automatic note(int lat);
    notes.push_back('{lat, expStack, expFrame, expExtra});
  endtask

  task automatic endTest(string nm);
    int n;
    n = 0;
    while (notes.size() > 0 && n < 100) begin
      tick(1);
      n++;
    end
    tick(2);
    $display("test %s done", nm);
  endtask

  task automatic rst(bit narrow);
    rst_n = 1'b0;
    busNarrowPin = narrow;
    expStack = 16'h0000;
    expFrame = 16'h0000;
    expExtra = 16'h0000;
    fl = 16'h0000;
    tick(10);
    check({busLockN, holdAck, dmaInhibit, stackPtr, flags}, {3'h4, 32'h0});
    rst_n = 1'b1;
    tick(4);
  endtask

  task automatic frameRelease(bit lock);
    if (lock) put(PFX_BUS_LOCK);
    put(OPC_FRAME_RELEASE);
    fetchValid = 1'b0;
    expStack = expFrame + WORD_STEP;
    expFrame = memWord(SEG_SS, expFrame);
    note(waitCycles == 4'h0 ? 8 : -1);
    tick(2);
    check({busLockN, dmaInhibit}, lock ? 2'h1 : 2'h2);
  endtask

  task automatic farLoad(bit lock, bit ovr, int lat);
    logic [2:0] r;
    logic [15:0] ea;
    frl_seg_t s;
    int st;
    r = {1'b0, 2'($random(seed))};
    ea = 16'($random(seed));
    s = ovr ? SEG_EXTRA : SEG_DS;
    if (lock) put(PFX_BUS_LOCK);
    if (ovr) put(PFX_SEG_EXTRA);
    put(OPC_FAR_LOAD_EXTRA);
    st = start;
    eaOffset = ea;
    put({2'h0, r, 3'h6});
    fetchValid = 1'b0;
    start = st;
    gprNotes.push_back({r, memWord(s, ea)});
    expExtra = memWord(s, ea + WORD_STEP);
    note(lat);
    tick(3);
    check(busLockN, !lock);
  endtask

  // ----
  // Result monitor
  // ----
  always @(negedge clk) begin
    frl_note_t n;
    if (nmiTake === 1'b1) nmiSeen++;
    if (foreignStart === 1'b1) startSeen++;
    if (gprWr.valid === 1'b1) begin
      if (gprNotes.size() == 0) check(64'h1, 64'h0);
      else check({gprWr.idx, gprWr.data}, gprNotes.pop_front());
    end
    if (instrDone === 1'b1) begin
      if (notes.size() == 0) check(64'h1, 64'h0);
      else begin
        n = notes.pop_front();
        if (n.lat >= 0) check(cyc - start, n.lat);
        check({stackPtr, framePtr}, {n.stack, n.frame});
        check(extraSeg, n.extra);
        check(flags, fl);
        check(busLockN, 1'b1);
      end
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    rst(1'b0);
    flagUpd = '{1'b1, 16'($random(seed))};
    fl = flagUpd.value;
    tick(1);
    flagUpd = '0;
    frameRelease(1'b0);
    endTest("release");
    frameRelease(1'b1);
    endTest("locked release");
    frameRelease(1'b0);
    endTest("lock lasts one instruction");
    waitCycles = 4'h3;
    frameRelease(1'b0);
    endTest("slow memory release");
    waitCycles = 4'h0;
    farLoad(1'b0, 1'b0, 18);
    endTest("far load wide");
    farLoad(1'b1, 1'b1, 18);
    endTest("locked far load with override");
    put(PFX_BUS_LOCK);
    put(PFX_SEG_EXTRA);
    put(PFX_ITER_EQ);
    put(8'hA4);
    fetchValid = 1'b0;
    holdReqPin = 1'b1;
    intrPin = 1'b1;
    nmiPin = 1'b1;
    tick(8);
    check({foreignOpcode, foreignPrefix}, {8'hA4, 6'h3C});
    check(startSeen, 1);
    check({busLockN, dmaInhibit, holdAck, intGrant}, 4'h4);
    check(nmiSeen, 1);
    note(-1);
    foreignDone = 1'b1;
    tick(1);
    foreignDone = 1'b0;
    endTest("locked iterated string");
    tick(4);
    check({busLockN, dmaInhibit, holdAck, intGrant}, 4'hB);
    holdReqPin = 1'b0;
    intrPin = 1'b0;
    nmiPin = 1'b0;
    tick(6);
    rst(1'b1);
    farLoad(1'b0, 1'b0, 26);
    endTest("far load narrow");
    frameRelease(1'b1);
    endTest("release narrow");
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  task automatic end_sim();
    $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
endmodule
